//--- inc/crx_pkg.sv
// Constants, types and helpers shared by the call/return execution block
// Contract
// RULE_01: Relative call opcode is 11011 plus signed 11-bit word offset, -1024..1023.
// RULE_02: Relative call pushes PC+2, then loads PC+2 plus twice the offset; flags kept.
// RULE_03: Relative call: push in phase two, PC write in phase four, second cycle idle.
// RULE_04: Reset opcode 0x00FF returns all master-clear reset registers and flags.
// RULE_05: Reset takes one cycle: decode phase one, reset in phase two, then nothing.
// RULE_06: Interrupt return pops stack top into PC in phase four; second cycle idle.
// RULE_07: Interrupt return sets the high or low priority global enable, nothing else.
// RULE_08: Shadow flag set restores working, flags and bank select; PC latches untouched.
// RULE_09: Interrupt return recognised by upper twelve bits 0000 0000 0001; the code matches the upper fifteen bits 0000 0000 0001 000.
// RULE_10: Return with literal loads its 8-bit immediate into working register; flags kept.
// RULE_11: Return with literal pops PC and writes working register in phase four.
// RULE_12: Return with literal leaves the PC high and upper latches unchanged.
// RULE_13: Two-cycle instructions discard the prefetch and change nothing in cycle two.
package crx_pkg;

  localparam int PC_W   = 21;
  localparam int SP_W   = 5;
  localparam int STK_N  = 31;
  localparam int W_W    = 8;
  localparam int ST_W   = 5;
  localparam int BSR_W  = 4;
  localparam int INT_W  = 3;
  localparam int UPL_W  = 5;

  typedef logic [PC_W-1:0] crx_pc_t;

  ////////////////////////////////////////////////////////////////////////////
  // Quarter phases of one instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode patterns
  localparam logic [15:0] RELATIVE_SUBROUTINE_CALL_MASK  = 16'hF800;
  localparam logic [15:0] RELATIVE_SUBROUTINE_CALL_MATCH = 16'hD800;
  localparam logic [15:0] RESET_CODE  = 16'h00FF;
  localparam logic [15:0] INTERRUPT_RETURN_MASK = 16'hFFFE;
  localparam logic [15:0] INTERRUPT_RETURN_MATCH = 16'h0010;
  localparam logic [15:0] RETURN_WITH_LITERAL_MASK  = 16'hFF00;
  localparam logic [15:0] RETURN_WITH_LITERAL_MATCH = 16'h0C00;
  localparam crx_pc_t     PC_STEP     = 21'h000002;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_PC    = 8'h04;
  localparam logic [7:0] ADR_W     = 8'h08;
  localparam logic [7:0] ADR_STAT  = 8'h0C;
  localparam logic [7:0] ADR_BSR   = 8'h10;
  localparam logic [7:0] ADR_WSH   = 8'h14;
  localparam logic [7:0] ADR_STSH  = 8'h18;
  localparam logic [7:0] ADR_BSSH  = 8'h1C;
  localparam logic [7:0] ADR_INT   = 8'h20;
  localparam logic [7:0] ADR_LATCH = 8'h24;
  localparam logic [7:0] ADR_STACK = 8'h28;

  // Field positions
  localparam int CTRL_PEND  = 16;
  localparam int CTRL_BUSY  = 17;
  localparam int CTRL_UNK   = 18;
  localparam int CTRL_OVF   = 19;
  localparam int CTRL_UNF   = 20;
  localparam int INT_HIGH   = 0;
  localparam int INT_LOW    = 1;
  localparam int INT_PRIO   = 2;
  localparam int LATCH_UPL  = 8;
  localparam int STACK_SP   = 24;

  // Reset values
  localparam crx_pc_t          RST_PC   = 21'h000000;
  localparam logic [W_W-1:0]   RST_W    = 8'h00;
  localparam logic [ST_W-1:0]  RST_ST   = 5'h00;
  localparam logic [BSR_W-1:0] RST_BSR  = 4'h0;
  localparam logic [INT_W-1:0] RST_INT  = 3'h0;
  localparam logic [W_W-1:0]   RST_PCH  = 8'h00;
  localparam logic [UPL_W-1:0] RST_PCU  = 5'h00;

  typedef enum {OP_OTHER, OP_RELATIVE_SUBROUTINE_CALL, OP_RESET, OP_INTERRUPT_RETURN, OP_RETURN_WITH_LITERAL} crx_op_e;
  typedef enum {CYC_READY, CYC_FIRST, CYC_SECOND} crx_cycle_e;

  typedef struct packed {
    crx_op_e      kind;
    logic [10:0]  offset;
    logic [7:0]   literal;
    logic         shadow;
  } crx_instr_s;

  function automatic crx_instr_s crx_decode(input logic [15:0] op);
    crx_instr_s d;
    d.kind    = OP_OTHER;
    d.offset  = op[10:0];
    d.literal = op[7:0];
    d.shadow  = op[0];
    if ((op & RELATIVE_SUBROUTINE_CALL_MASK) == RELATIVE_SUBROUTINE_CALL_MATCH)
      d.kind = OP_RELATIVE_SUBROUTINE_CALL;
    else if (op == RESET_CODE)
      d.kind = OP_RESET;
    else if ((op & INTERRUPT_RETURN_MASK) == INTERRUPT_RETURN_MATCH)
      d.kind = OP_INTERRUPT_RETURN;
    else if ((op & RETURN_WITH_LITERAL_MASK) == RETURN_WITH_LITERAL_MATCH)
      d.kind = OP_RETURN_WITH_LITERAL;
    return d;
  endfunction : crx_decode

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] crx_merge(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = dat[8*i +: 8];
    end
    return r;
  endfunction : crx_merge

endpackage : crx_pkg

//--- rtl/crx_exec.sv
// Call, reset and return instruction execution with a Wishbone register port
`timescale 1ns/1ns
module crx_exec
  import crx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  output logic             flushFetch,
  output logic             softResetPulse,
  output logic [1:0]       quarterPhase
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [1:0]        phase_q;
  crx_cycle_e        cyc_q;
  crx_cycle_e        cyc_d;
  crx_instr_s        exec_q;
  logic [15:0]       opcode_q;
  logic              pending_q;
  logic              unknown_q;
  crx_pc_t           pc_q;
  logic [W_W-1:0]    w_q;
  logic [ST_W-1:0]   status_q;
  logic [BSR_W-1:0]  bsr_q;
  logic [W_W-1:0]    wShadow_q;
  logic [ST_W-1:0]   statusShadow_q;
  logic [BSR_W-1:0]  bsrShadow_q;
  logic [INT_W-1:0]  intEnable_q;
  logic [W_W-1:0]    pcHigh_q;
  logic [UPL_W-1:0]  pcUpper_q;
  logic              ack_q;
  logic [31:0]       rdData_q;
  logic              flush_q;
  logic              softRst_q;

  logic              busAccess;
  logic              busWrite;
  logic [31:0]       rdMux;
  logic              takeInstr;
  logic              atQ2;
  logic              atQ4;
  logic              doReset;
  logic              doPush;
  logic              doPop;
  logic              twoCycle;
  crx_pc_t           pcPlus2;
  crx_pc_t           callTarget;
  crx_pc_t           stackTop;
  logic [SP_W-1:0]   stackDepth;
  logic              stackOvf;
  logic              stackUnf;
  crx_instr_s        decoded;

  function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : regHit

  function automatic logic wrHit(input logic [7:0] off);
    return busWrite && regHit(adr_i, off);
  endfunction : wrHit

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ack_o          = ack_q;
  assign dat_o          = rdData_q;
  assign flushFetch     = flush_q;
  assign softResetPulse = softRst_q;
  assign quarterPhase   = phase_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  // Requests only start on a fresh access, so each gets exactly one ack
  assign busAccess = cyc_i && stb_i && !ack_q;
  // Writes land on the ack edge, when the master is known to hold its data
  assign busWrite  = cyc_i && stb_i && we_i && ack_q;
  assign decoded   = crx_decode(opcode_q);

  assign takeInstr = (cyc_q == CYC_READY) && (phase_q == PH_Q1) && pending_q;
  assign atQ2      = (cyc_q == CYC_FIRST) && (phase_q == PH_Q2);
  assign atQ4      = (cyc_q == CYC_FIRST) && (phase_q == PH_Q4);
  assign doReset   = atQ2 && (exec_q.kind == OP_RESET);                 // [RULE_05]
  assign doPush    = atQ2 && (exec_q.kind == OP_RELATIVE_SUBROUTINE_CALL);                 // [RULE_03]
  assign doPop     = atQ4 && ((exec_q.kind == OP_INTERRUPT_RETURN) ||
                              (exec_q.kind == OP_RETURN_WITH_LITERAL));               // [RULE_06] [RULE_11]
  assign twoCycle  = (exec_q.kind == OP_RELATIVE_SUBROUTINE_CALL) ||
                     (exec_q.kind == OP_INTERRUPT_RETURN) ||
                     (exec_q.kind == OP_RETURN_WITH_LITERAL);

  // PC still points at this word, so the step past it is added to form the target
  assign pcPlus2    = pc_q + PC_STEP;
  assign callTarget = pcPlus2 +
                      {{(PC_W-12){exec_q.offset[10]}}, exec_q.offset, 1'b0}; // [RULE_01] [RULE_02]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_Q1;
    end else begin
      phase_q <= phase_q + PH_STEP;
    end
  end

  always_comb begin
    cyc_d = cyc_q;
    case (cyc_q)
      CYC_READY: begin
        if (takeInstr) cyc_d = CYC_FIRST;
      end
      CYC_FIRST: begin
        if (phase_q == PH_Q4) cyc_d = twoCycle ? CYC_SECOND : CYC_READY; // [RULE_03] [RULE_05]
      end
      CYC_SECOND: begin
        if (phase_q == PH_Q4) cyc_d = CYC_READY;                         // [RULE_13]
      end
      default: begin
        cyc_d = CYC_READY;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_q <= CYC_READY;
    end else begin
      cyc_q <= cyc_d;
    end
  end

  // Prefetched word is thrown away for the whole idle second cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= (cyc_d == CYC_SECOND);                                  // [RULE_13]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      softRst_q <= 1'b0;
    end else begin
      softRst_q <= doReset;                                              // [RULE_04]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction issue

  // A second issue while one waits is refused; software polls the pending bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_q <= 1'b0;
      opcode_q  <= '0;
    end else if (wrHit(ADR_CTRL) && (&sel_i[1:0]) && !pending_q) begin
      pending_q <= 1'b1;
      opcode_q  <= dat_i[15:0];
    end else if (takeInstr) begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exec_q    <= '0;
      unknown_q <= 1'b0;
    end else if (takeInstr) begin
      exec_q    <= decoded;                                              // [RULE_09]
      unknown_q <= (decoded.kind == OP_OTHER);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and latches

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= RST_PC;
    end else if (doReset) begin
      pc_q <= RST_PC;                                                    // [RULE_04]
    end else if (atQ4) begin
      case (exec_q.kind)
        OP_RELATIVE_SUBROUTINE_CALL:  pc_q <= callTarget;                                   // [RULE_02] [RULE_03]
        OP_INTERRUPT_RETURN: pc_q <= stackTop;                                     // [RULE_06]
        OP_RETURN_WITH_LITERAL:  pc_q <= stackTop;                                     // [RULE_11]
        OP_RESET:  pc_q <= pc_q;
        default:   pc_q <= pcPlus2;
      endcase
    end else if (wrHit(ADR_PC)) begin
      pc_q <= PC_W'(crx_merge(32'(pc_q), dat_i, sel_i));
    end
  end

  // Returns reload only the counter itself, never these latches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcHigh_q  <= RST_PCH;
      pcUpper_q <= RST_PCU;
    end else if (doReset) begin
      pcHigh_q  <= RST_PCH;
      pcUpper_q <= RST_PCU;
    end else if (wrHit(ADR_LATCH)) begin                                 // [RULE_08] [RULE_12]
      pcHigh_q  <= W_W'(crx_merge(32'(pcHigh_q), dat_i, sel_i));
      pcUpper_q <= UPL_W'(crx_merge(32'(pcUpper_q) << LATCH_UPL, dat_i, sel_i) >> LATCH_UPL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working, flags and bank select

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_q <= RST_W;
    end else if (doReset) begin
      w_q <= RST_W;
    end else if (atQ4 && exec_q.kind == OP_RETURN_WITH_LITERAL) begin
      w_q <= exec_q.literal;                                             // [RULE_10] [RULE_11]
    end else if (atQ4 && exec_q.kind == OP_INTERRUPT_RETURN && exec_q.shadow) begin
      w_q <= wShadow_q;                                                  // [RULE_08]
    end else if (wrHit(ADR_W)) begin
      w_q <= W_W'(crx_merge(32'(w_q), dat_i, sel_i));
    end
  end

  // Calls and literal returns leave the flags alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= RST_ST;
    end else if (doReset) begin
      status_q <= RST_ST;                                                // [RULE_04]
    end else if (atQ4 && exec_q.kind == OP_INTERRUPT_RETURN && exec_q.shadow) begin
      status_q <= statusShadow_q;                                        // [RULE_08]
    end else if (wrHit(ADR_STAT)) begin
      status_q <= ST_W'(crx_merge(32'(status_q), dat_i, sel_i));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bsr_q <= RST_BSR;
    end else if (doReset) begin
      bsr_q <= RST_BSR;
    end else if (atQ4 && exec_q.kind == OP_INTERRUPT_RETURN && exec_q.shadow) begin
      bsr_q <= bsrShadow_q;                                              // [RULE_08]
    end else if (wrHit(ADR_BSR)) begin
      bsr_q <= BSR_W'(crx_merge(32'(bsr_q), dat_i, sel_i));
    end
  end

  // Shadows are loaded by software only; the reset opcode leaves them alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wShadow_q      <= RST_W;
      statusShadow_q <= RST_ST;
      bsrShadow_q    <= RST_BSR;
    end else begin
      if (wrHit(ADR_WSH)) begin
        wShadow_q <= W_W'(crx_merge(32'(wShadow_q), dat_i, sel_i));
      end
      if (wrHit(ADR_STSH)) begin
        statusShadow_q <= ST_W'(crx_merge(32'(statusShadow_q), dat_i, sel_i));
      end
      if (wrHit(ADR_BSSH)) begin
        bsrShadow_q <= BSR_W'(crx_merge(32'(bsrShadow_q), dat_i, sel_i));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global interrupt enables

  // Without priorities the high bit is the single global enable; with them
  // a clear high bit means the high level handler is the one returning
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intEnable_q <= RST_INT;
    end else if (doReset) begin
      intEnable_q <= RST_INT;
    end else if (atQ4 && exec_q.kind == OP_INTERRUPT_RETURN) begin
      if (!intEnable_q[INT_PRIO] || !intEnable_q[INT_HIGH]) begin
        intEnable_q[INT_HIGH] <= 1'b1;                                   // [RULE_07]
      end else begin
        intEnable_q[INT_LOW] <= 1'b1;                                    // [RULE_07]
      end
    end else if (wrHit(ADR_INT)) begin
      intEnable_q <= INT_W'(crx_merge(32'(intEnable_q), dat_i, sel_i));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return stack

  crx_return_stack u_stack (
    .clk       (clk),
    .rst       (rst),
    .clear     (doReset),
    .push      (doPush),                                                 // [RULE_02]
    .pushData  (pcPlus2),
    .pop       (doPop),
    .top       (stackTop),
    .depth     (stackDepth),
    .overflow  (stackOvf),
    .underflow (stackUnf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  always_comb begin
    rdMux = '0;
    if (regHit(adr_i, ADR_CTRL)) begin
      rdMux[15:0]      = opcode_q;
      rdMux[CTRL_PEND] = pending_q;
      rdMux[CTRL_BUSY] = (cyc_q != CYC_READY);
      rdMux[CTRL_UNK]  = unknown_q;
      rdMux[CTRL_OVF]  = stackOvf;
      rdMux[CTRL_UNF]  = stackUnf;
    end else if (regHit(adr_i, ADR_PC)) begin
      rdMux[PC_W-1:0] = pc_q;
    end else if (regHit(adr_i, ADR_W)) begin
      rdMux[W_W-1:0] = w_q;
    end else if (regHit(adr_i, ADR_STAT)) begin
      rdMux[ST_W-1:0] = status_q;
    end else if (regHit(adr_i, ADR_BSR)) begin
      rdMux[BSR_W-1:0] = bsr_q;
    end else if (regHit(adr_i, ADR_WSH)) begin
      rdMux[W_W-1:0] = wShadow_q;
    end else if (regHit(adr_i, ADR_STSH)) begin
      rdMux[ST_W-1:0] = statusShadow_q;
    end else if (regHit(adr_i, ADR_BSSH)) begin
      rdMux[BSR_W-1:0] = bsrShadow_q;
    end else if (regHit(adr_i, ADR_INT)) begin
      rdMux[INT_W-1:0] = intEnable_q;
    end else if (regHit(adr_i, ADR_LATCH)) begin
      rdMux[W_W-1:0]          = pcHigh_q;
      rdMux[LATCH_UPL +: UPL_W] = pcUpper_q;
    end else if (regHit(adr_i, ADR_STACK)) begin
      rdMux[PC_W-1:0]          = stackTop;
      rdMux[STACK_SP +: SP_W]  = stackDepth;
    end
  end

  // One wait-free cycle: ack and data follow the request edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q    <= 1'b0;
      rdData_q <= '0;
    end else begin
      ack_q <= busAccess;
      if (busAccess) rdData_q <= we_i ? '0 : rdMux;
    end
  end

endmodule : crx_exec

//--- rtl/crx_return_stack.sv
// Hardware return stack with overflow and underflow flags
`timescale 1ns/1ns
module crx_return_stack
  import crx_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      clear,
  input  wire logic      push,
  input  wire crx_pc_t   pushData,
  input  wire logic      pop,
  output crx_pc_t        top,
  output logic [SP_W-1:0] depth,
  output logic           overflow,
  output logic           underflow
);

  crx_pc_t         mem [STK_N];
  logic [SP_W-1:0] sp_q;
  logic            ovf_q;
  logic            unf_q;
  logic            full;
  logic            empty;

  assign full  = (sp_q == SP_W'(STK_N));
  assign empty = (sp_q == '0);
  // Empty stack reads as zero rather than stale data
  assign top       = empty ? RST_PC : mem[sp_q - SP_W'(1)];
  assign depth     = sp_q;
  assign overflow  = ovf_q;
  assign underflow = unf_q;

  always_ff @(posedge clk) begin
    if (push && !full) mem[sp_q] <= pushData;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_q <= '0;
    end else if (clear) begin
      sp_q <= '0;
    end else if (push && !full) begin
      sp_q <= sp_q + SP_W'(1);
    end else if (pop && !empty) begin
      sp_q <= sp_q - SP_W'(1);
    end
  end

  // Sticky; a full push or an empty pop is dropped, not wrapped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else if (clear) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      if (push && full) ovf_q <= 1'b1;
      if (pop && empty) unf_q <= 1'b1;
    end
  end

endmodule : crx_return_stack

//--- tb/crx_exec_chk.sv
// Port checks for the call and return execution block
`timescale 1ns/1ns
module crx_exec_chk
  import crx_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic        flushFetch,
  input wire logic        softResetPulse,
  input wire logic [1:0]  quarterPhase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  chk_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not acknowledged next cycle");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  chk_write_zero: assert property (ack_o && $past(we_i) |-> dat_o == 32'h0)
    else $error("read data not zero on write ack");
  // Phase counter is what every instruction step is timed against
  // The edge that ends reset still holds the counter at zero, so skip it
  chk_phase_step: assert property (!$past(rst) |-> quarterPhase == 2'($past(quarterPhase) + 2'h1))
    else $error("quarter phase did not advance by one");
  chk_flush_start: assert property ($rose(flushFetch) |-> quarterPhase == PH_Q1)
    else $error("idle cycle not aligned to instruction cycle");
  chk_flush_len: assert property ($rose(flushFetch) |-> flushFetch[*4] ##1 !flushFetch)
    else $error("idle cycle not four clocks");
  chk_srst_pulse: assert property (softResetPulse |=> !softResetPulse)
    else $error("soft reset pulse too long");
  chk_srst_phase: assert property (softResetPulse |-> quarterPhase == 2'h2 && !flushFetch)
    else $error("soft reset pulse at wrong phase");

  ////////////////////////////////////////////////////////////////////////////
  cov_flush: cover property ($rose(flushFetch));
  cov_srst: cover property (softResetPulse);
  cov_read: cover property (ack_o && !$past(we_i));
endmodule : crx_exec_chk

bind crx_exec crx_exec_chk u_chk (.clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
  .flushFetch(flushFetch), .softResetPulse(softResetPulse), .quarterPhase(quarterPhase));

//--- tb/testbench.sv
// Self-checking bench for the call and return execution block
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failCount++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module testbench
  import crx_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic        flush;
  logic        srst;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat;
  logic [31:0] rdat;
  logic [1:0]  ph;
  logic [15:0] r;
  int          failCount = 0;
  int          checked = 0;

  always #4 clk = ~clk;

  crx_exec dut (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .ack_o(ack), .dat_o(rdat), .flushFetch(flush),
    .softResetPulse(srst), .quarterPhase(ph));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt

  function automatic crx_pc_t tgt(input crx_pc_t p, input logic [10:0] n);
    return p + PC_STEP + {{9{n[10]}}, n, 1'b0};
  endfunction : tgt

  function automatic logic [2:0] intExp(input logic [2:0] e);
    return (!e[2] || !e[0]) ? (e | 3'h1) : (e | 3'h2);
  endfunction : intExp

  task automatic finalReport();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finalReport

  // Opcode writes use the low two lanes only, as the issue port expects
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= (a == ADR_CTRL) ? 4'h3 : 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      failCount++;
      finalReport();
    end
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask : rd

  task automatic issue(input logic [15:0] op);
    logic [31:0] q;
    int n;
    wr(ADR_CTRL, {16'h0000, op});
    n = 0;
    do begin
      wb(1'b0, ADR_CTRL, 32'h0, q);
      n++;
    end while (q[CTRL_BUSY:CTRL_PEND] !== 2'h0 && n < 30);
    if (n >= 30) begin
      failCount++;
      finalReport();
    end
  endtask : issue

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    crx_pc_t     pc;
    crx_pc_t     ret;
    logic [10:0] n;
    logic [7:0]  k;
    logic [4:0]  st;
    logic [12:0] lt;
    logic [2:0]  e;
    logic        s;
    clk = 1'b0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    r   = 16'h0002;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a <= 8'h2C; a += 4) rd(a[7:0], 32'h0);
    for (int i = 0; i < 8; i++) begin
      r = nxt(r);
      n = (i == 0) ? 11'h400 : (i == 1) ? 11'h3FF : r[10:0];
      pc = (i == 2) ? 21'h1FFFFE : {4'h0, r, 1'b0};
      st = r[15:11];
      r = nxt(r);
      k = r[7:0];
      lt = r[15:3];
      s = r[0];
      e = (i == 3) ? 3'h5 : r[3:1];
      ret = pc + PC_STEP;
      wr(ADR_PC, {11'h0, pc});
      wr(ADR_STAT, {27'h0, st});
      issue(RELATIVE_SUBROUTINE_CALL_MATCH | {5'h00, n});
      rd(ADR_PC, {11'h0, tgt(pc, n)});
      rd(ADR_STACK, {3'h0, 5'h01, 3'h0, ret});
      rd(ADR_STAT, {27'h0, st});
      wr(ADR_LATCH, {19'h0, lt});
      issue(RETURN_WITH_LITERAL_MATCH | {8'h00, k});
      rd(ADR_W, {24'h0, k});
      rd(ADR_PC, {11'h0, ret});
      rd(ADR_LATCH, {19'h0, lt});
      rd(ADR_STACK, 32'h0);
      issue(RELATIVE_SUBROUTINE_CALL_MATCH);
      wr(ADR_WSH, {24'h0, ~k});
      wr(ADR_STSH, {27'h0, ~st});
      wr(ADR_BSSH, {28'h0, lt[7:4]});
      wr(ADR_BSR, {28'h0, lt[3:0]});
      wr(ADR_INT, {29'h0, e});
      issue(INTERRUPT_RETURN_MATCH | {15'h0, s});
      rd(ADR_PC, {11'h0, ret + PC_STEP});
      rd(ADR_INT, {29'h0, intExp(e)});
      rd(ADR_W, {24'h0, s ? ~k : k});
      rd(ADR_STAT, {27'h0, s ? ~st : st});
      rd(ADR_BSR, {28'h0, s ? lt[7:4] : lt[3:0]});
      rd(ADR_LATCH, {19'h0, lt});
    end
    wr(ADR_W, 32'hA5);
    wr(ADR_LATCH, 32'h1FFF);
    wr(ADR_INT, 32'h7);
    issue(RELATIVE_SUBROUTINE_CALL_MATCH);
    issue(RESET_CODE);
    for (int a = 4; a <= 8'h28; a += 4) begin
      if (a < 8'h14 || a > 8'h1C) rd(a[7:0], 32'h0);
    end
    rd(ADR_WSH, {24'h0, ~k});
    wr(ADR_PC, 32'h100);
    issue(16'h0012);
    rd(ADR_PC, 32'h102);
    rd(ADR_CTRL, 32'h0004_0012);
    issue(RETURN_WITH_LITERAL_MATCH);
    rd(ADR_CTRL, 32'h0010_0C00);
    wr(8'h2C, 32'hFFFF_FFFF);
    rd(8'h2C, 32'h0);
    wr(ADR_STACK, 32'h1);
    rd(ADR_STACK, 32'h0);
    finalReport();
  end
endmodule : testbench
